//--- logic/rtsfs_pkg.sv
// package for the ramp time select and fast stop block
// assumes a 125 MHz ref_clk and a 32-bit Avalon-MM register port
`default_nettype none
package rtsfs_pkg;
  localparam int FREQ_W = 12;
  localparam int TIME_W = 16;
  localparam int NUM_DI = 4;
  // -------------------------------------------------
  // register byte offsets
  // -------------------------------------------------
  localparam logic [7:0] OFS_ACC1 = 8'h00;
  localparam logic [7:0] OFS_DEC1 = 8'h04;
  localparam logic [7:0] OFS_ACC2 = 8'h08;
  localparam logic [7:0] OFS_DEC2 = 8'h0C;
  localparam logic [7:0] OFS_FSTOP = 8'h10;
  localparam logic [7:0] OFS_SWF = 8'h14;
  localparam logic [7:0] OFS_MAXF = 8'h18;
  localparam logic [7:0] OFS_DIFN = 8'h1C;
  localparam logic [7:0] OFS_DOFN = 8'h20;
  localparam logic [7:0] OFS_CTRL = 8'h24;
  localparam logic [7:0] OFS_STAT = 8'h28;
  // -------------------------------------------------
  // fields and reset values (times in 0.1 s, frequencies in 0.1 Hz)
  // -------------------------------------------------
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_TGT_LSB = 16;
  localparam int STAT_FS_BIT = 16;
  localparam int STAT_PAIR2_BIT = 17;
  localparam int STAT_BLK_BIT = 18;
  localparam logic [TIME_W-1:0] RAMP_TIME_RST = 16'h012C;
  localparam logic [TIME_W-1:0] FSTOP_TIME_RST = 16'h0064;
  localparam logic [FREQ_W-1:0] SWF_RST = 12'h000;
  localparam logic [FREQ_W-1:0] MAXF_RST = 12'h258;
  // -------------------------------------------------
  // function codes of the digital inputs and the output
  // -------------------------------------------------
  localparam logic [7:0] FN_RAMP_SEL = 8'h07;
  localparam logic [7:0] FN_FSTOP_NO = 8'h15;
  localparam logic [7:0] FN_FSTOP_NC = 8'h17;
  localparam logic [7:0] FN_DO_FSTOP = 8'h4C;
  // -------------------------------------------------
  // timing
  // -------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int RAMP_TICK_US = 1000;
  localparam int RAMP_TICK_CYC = RAMP_TICK_US * CLK_MHZ;
  localparam int TIME_UNIT_US = 100000;
  localparam int TICKS_PER_UNIT = TIME_UNIT_US / RAMP_TICK_US;
  typedef struct packed {
    logic [TIME_W-1:0] accel;
    logic [TIME_W-1:0] decel;
  } rtsfs_pair_t;
endpackage
`default_nettype wire

//--- logic/rtsfs_ramp_ctrl.sv
// ramp time pair selection, linear frequency ramp and latched fast stop
// assumes di_pin comes from contacts (asynchronous), fault_fast_stop from ref_clk logic
//
// Summary of operation
// - an accel time is the time to ramp from zero to the maximum output frequency.
// - a decel time is the time to ramp from the maximum output frequency to zero.
// - with no input assigned to ramp selection and automatic switching off the first accel/decel pair is used.
// - an input with function 07 selects pair one when low and pair two when high.
// - automatic switching uses pair two at or below the switch frequency and pair one above it.
// - an input-chosen pair overrides automatic switching.
// - a switch frequency of zero (the reset value) disables automatic switching.
// - fast stop, with its own time, starts on a fault or an input coded 15 (open) or 17 (closed).
// - the fast stop request is latched so a momentary input is enough.
// - restart waits for decel end, release of the fast stop input and a cycled run command.
// - an output coded 4C is on for as long as fast stop is active, one ref_clk cycle later.
//
// Our own choices: the register addresses and register access over Avalon-MM.
`default_nettype none
module rtsfs_ramp_ctrl #(
  parameter int TICK_CYC = rtsfs_pkg::RAMP_TICK_CYC
)(
  input wire logic ref_clk, // 125 MHz clock
  input wire logic rst_n, // asynchronous reset, active low
  input wire logic [7:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // low for the completing cycle
  input wire logic [rtsfs_pkg::NUM_DI-1:0] di_pin, // contact inputs
  input wire logic fault_fast_stop, // fault asking for fast stop
  output logic do_pin, // function-coded digital output
  output logic [rtsfs_pkg::FREQ_W-1:0] out_freq, // ramped frequency, 0.1 Hz
  output logic fast_stop_active // fast stop in progress
);
  localparam int TW = rtsfs_pkg::TIME_W;
  localparam int FW = rtsfs_pkg::FREQ_W;
  localparam int ND = rtsfs_pkg::NUM_DI;
  localparam int CW = $clog2(TICK_CYC);

  // -------------------------------------------------
  // register bus
  // -------------------------------------------------
  logic [TW-1:0] acc1_ff, dec1_ff, acc2_ff, dec2_ff, fstop_ff;
  logic [FW-1:0] swf_ff, maxf_ff, tgt_ff, freq_ff;
  logic [31:0] difn_ff;
  logic [7:0] dofn_ff;
  logic run_ff, fs_active_ff, blk_ff, do_ff, wait_ff;
  logic [31:0] rdata_ff, rd_mux;
  logic use_second;

  wire bus_req = avs_read | avs_write;
  wire wr_fire = avs_write & ~wait_ff;
  wire [31:0] wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                       {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [31:0] wr_val = (rd_mux & ~wmask) | (avs_writedata & wmask);
  wire [31:0] stat_val = {13'h0000, blk_ff, use_second, fs_active_ff, 4'h0, freq_ff};

  always_comb
  begin
    case (avs_address)
      rtsfs_pkg::OFS_ACC1: rd_mux = {16'h0000, acc1_ff};
      rtsfs_pkg::OFS_DEC1: rd_mux = {16'h0000, dec1_ff};
      rtsfs_pkg::OFS_ACC2: rd_mux = {16'h0000, acc2_ff};
      rtsfs_pkg::OFS_DEC2: rd_mux = {16'h0000, dec2_ff};
      rtsfs_pkg::OFS_FSTOP: rd_mux = {16'h0000, fstop_ff};
      rtsfs_pkg::OFS_SWF: rd_mux = {20'h00000, swf_ff};
      rtsfs_pkg::OFS_MAXF: rd_mux = {20'h00000, maxf_ff};
      rtsfs_pkg::OFS_DIFN: rd_mux = difn_ff;
      rtsfs_pkg::OFS_DOFN: rd_mux = {24'h000000, dofn_ff};
      rtsfs_pkg::OFS_CTRL: rd_mux = {4'h0, tgt_ff, 15'h0000, run_ff};
      rtsfs_pkg::OFS_STAT: rd_mux = stat_val;
      default: rd_mux = 32'h00000000;
    endcase
  end

  // one wait cycle per access keeps the read path registered
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wait_ff <= 1'b1;
      rdata_ff <= 32'h00000000;
    end
    else
    begin
      wait_ff <= ~(bus_req & wait_ff);
      if (avs_read & wait_ff)
        rdata_ff <= rd_mux;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc1_ff <= rtsfs_pkg::RAMP_TIME_RST;
      dec1_ff <= rtsfs_pkg::RAMP_TIME_RST;
      acc2_ff <= rtsfs_pkg::RAMP_TIME_RST;
      dec2_ff <= rtsfs_pkg::RAMP_TIME_RST;
      fstop_ff <= rtsfs_pkg::FSTOP_TIME_RST;
      swf_ff <= rtsfs_pkg::SWF_RST;
      maxf_ff <= rtsfs_pkg::MAXF_RST;
      difn_ff <= 32'h00000000;
      dofn_ff <= 8'h00;
      run_ff <= 1'b0;
      tgt_ff <= 12'h000;
    end
    else if (wr_fire)
    begin
      case (avs_address)
        rtsfs_pkg::OFS_ACC1: acc1_ff <= wr_val[TW-1:0];
        rtsfs_pkg::OFS_DEC1: dec1_ff <= wr_val[TW-1:0];
        rtsfs_pkg::OFS_ACC2: acc2_ff <= wr_val[TW-1:0];
        rtsfs_pkg::OFS_DEC2: dec2_ff <= wr_val[TW-1:0];
        rtsfs_pkg::OFS_FSTOP: fstop_ff <= wr_val[TW-1:0];
        rtsfs_pkg::OFS_SWF: swf_ff <= wr_val[FW-1:0];
        rtsfs_pkg::OFS_MAXF: maxf_ff <= wr_val[FW-1:0];
        rtsfs_pkg::OFS_DIFN: difn_ff <= wr_val;
        rtsfs_pkg::OFS_DOFN: dofn_ff <= wr_val[7:0];
        rtsfs_pkg::OFS_CTRL:
        begin
          run_ff <= wr_val[rtsfs_pkg::CTRL_RUN_BIT];
          tgt_ff <= wr_val[rtsfs_pkg::CTRL_TGT_LSB +: FW];
        end
        default: ;
      endcase
    end
  end

  // -------------------------------------------------
  // contact inputs: three stages, a change counts when stages two and three agree
  // -------------------------------------------------
  logic [2:0] di_sync_ff [ND];
  logic [ND-1:0] di_lvl_ff, is_sel, sel_hi, fs_req;

  for (genvar i = 0; i < ND; i++)
  begin : g_di
    wire [7:0] fn = difn_ff[8*i +: 8];
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        di_sync_ff[i] <= 3'h0;
        di_lvl_ff[i] <= 1'b0;
      end
      else
      begin
        di_sync_ff[i] <= {di_sync_ff[i][1:0], di_pin[i]};
        if (di_sync_ff[i][1] == di_sync_ff[i][2])
          di_lvl_ff[i] <= di_sync_ff[i][2];
      end
    end
    assign is_sel[i] = (fn == rtsfs_pkg::FN_RAMP_SEL);
    assign sel_hi[i] = is_sel[i] & di_lvl_ff[i];
    assign fs_req[i] = ((fn == rtsfs_pkg::FN_FSTOP_NO) & di_lvl_ff[i]) |
                       ((fn == rtsfs_pkg::FN_FSTOP_NC) & ~di_lvl_ff[i]);
  end

  // -------------------------------------------------
  // ramp pair selection
  // -------------------------------------------------
  wire sel_assigned = |is_sel;
  wire sel_in_hi = |sel_hi;
  wire auto_on = (swf_ff != 12'h000);
  wire auto_second = auto_on & (freq_ff <= swf_ff);
  assign use_second = sel_assigned ? sel_in_hi : auto_second;
  wire rtsfs_pkg::rtsfs_pair_t pair = use_second ? {acc2_ff, dec2_ff} : {acc1_ff, dec1_ff};

  // -------------------------------------------------
  // fast stop latch and restart interlock
  // -------------------------------------------------
  logic fs_level_d_ff;
  wire fs_level = (|fs_req) | fault_fast_stop;
  wire fs_trig = fs_level & ~fs_level_d_ff;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fs_level_d_ff <= 1'b0;
      fs_active_ff <= 1'b0;
      blk_ff <= 1'b0;
      do_ff <= 1'b0;
    end
    else
    begin
      fs_level_d_ff <= fs_level;
      // a new request wins over the end of the previous one
      if (fs_trig)
        fs_active_ff <= 1'b1;
      else if (freq_ff == 12'h000)
        fs_active_ff <= 1'b0;
      if (fs_trig)
        blk_ff <= 1'b1;
      else if (~fs_active_ff & ~fs_level & ~run_ff)
        blk_ff <= 1'b0;
      do_ff <= (dofn_ff == rtsfs_pkg::FN_DO_FSTOP) & fs_active_ff;
    end
  end

  // -------------------------------------------------
  // linear ramp: pending credit gains maxf per tick, one unit step costs span
  // -------------------------------------------------
  logic [CW-1:0] tick_cnt_ff;
  logic tick_ff;
  logic [23:0] pend_ff;

  wire [FW-1:0] tgt_lim = (tgt_ff > maxf_ff) ? maxf_ff : tgt_ff;
  wire [FW-1:0] goal = (run_ff & ~blk_ff & ~fs_active_ff) ? tgt_lim : 12'h000;
  wire up = goal > freq_ff;
  wire dn = goal < freq_ff;
  wire [TW-1:0] tsel = fs_active_ff ? fstop_ff : (up ? pair.accel : pair.decel);
  wire [23:0] span = 24'(tsel) * 24'(rtsfs_pkg::TICKS_PER_UNIT);
  wire step = (up | dn) & (pend_ff >= span);
  wire [23:0] pend_add = tick_ff ? 24'(maxf_ff) : 24'h000000;
  wire [23:0] pend_sub = step ? span : 24'h000000;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_cnt_ff <= '0;
      tick_ff <= 1'b0;
      pend_ff <= 24'h000000;
      freq_ff <= 12'h000;
    end
    else
    begin
      tick_ff <= (tick_cnt_ff == CW'(TICK_CYC - 1));
      tick_cnt_ff <= (tick_cnt_ff == CW'(TICK_CYC - 1)) ? '0 : tick_cnt_ff + 1'b1;
      pend_ff <= (up | dn) ? pend_ff - pend_sub + pend_add : 24'h000000;
      if (step)
        freq_ff <= up ? freq_ff + 1'b1 : freq_ff - 1'b1;
    end
  end

  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign do_pin = do_ff;
  assign out_freq = freq_ff;
  assign fast_stop_active = fs_active_ff;

  // -------------------------------------------------
  // checks
  // -------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_fs_start;
    fs_trig ##1 fs_active_ff;
  endsequence

  sequence s_fs_end;
    fs_active_ff && freq_ff == 12'h000 && !fs_trig ##1 !fs_active_ff;
  endsequence

  chk_bus_answer: assert property (bus_req && wait_ff |=> !wait_ff ##1 wait_ff)
    else $error("bus answer not one cycle");
  chk_step_unit: assert property (step |=> (freq_ff - $past(freq_ff) == 12'h001) ||
                                     ($past(freq_ff) - freq_ff == 12'h001))
    else $error("ramp step not one unit");
  chk_step_spacing: assert property (step && !tick_ff && span > 24'(maxf_ff)
                                     |=> !step)
    else $error("ramp stepped without credit");
  chk_fs_latch: assert property (s_fs_start ##1 (fs_active_ff && freq_ff != 12'h000)
                                 |=> fs_active_ff)
    else $error("fast stop dropped before zero");
  chk_fs_no_accel: assert property (fs_active_ff |=> freq_ff <= $past(freq_ff))
    else $error("frequency rose in fast stop");
  chk_fs_do_out: assert property (s_fs_end and (dofn_ff == rtsfs_pkg::FN_DO_FSTOP)[*2] |=> !do_ff)
    else $error("fast stop output not released");
  chk_fs_do_on: assert property (fs_active_ff && dofn_ff == rtsfs_pkg::FN_DO_FSTOP |=> do_ff)
    else $error("fast stop output not set");
  chk_restart_block: assert property (blk_ff && (fs_level || run_ff) |=> blk_ff ##0 goal == 12'h000)
    else $error("restart allowed too early");
  chk_fs_trigger: assert property (fs_trig |=> fs_active_ff && blk_ff)
    else $error("fast stop not started");
  chk_default_pair: assert property (!sel_assigned && !auto_on |-> !use_second)
    else $error("default pair not used");
  chk_in_priority: assert property (sel_assigned |-> use_second == sel_in_hi)
    else $error("input pair not obeyed");
  chk_auto_switch: assert property (auto_on && !sel_assigned |-> use_second == (freq_ff <= swf_ff))
    else $error("automatic pair wrong");
endmodule
`default_nettype wire

//--- bench/rtsfs_contacts.sv
// contact model for the multifunction digital inputs of the drive
// assumes contact_cmd is changed by the bench right after rising edges of ref_clk
`default_nettype none
module rtsfs_contacts (
  input wire logic ref_clk, // drive clock, paces contact travel only
  input wire logic [rtsfs_pkg::NUM_DI-1:0] contact_cmd, // wanted contact state
  output logic [rtsfs_pkg::NUM_DI-1:0] di_pin // level at the input terminals
);
  timeunit 1ns;
  timeprecision 1ps;
  initial di_pin = '0;
  // travel time varies, so the drive never sees a change at the same edge as the command
  always @(posedge ref_clk)
  begin
    if (di_pin !== contact_cmd)
    begin
      repeat ($urandom_range(3)) @(posedge ref_clk);
      di_pin <= contact_cmd;
    end
  end
endmodule
`default_nettype wire

//--- bench/rtsfs_ramp_ctrl_tb.sv
// self-checking bench for the ramp pair selection and fast stop logic
// assumes the contact model drives di_pin and max frequency stays at its reset value
`default_nettype none
module rtsfs_ramp_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 10;
  // fast stop time above max frequency per tick, so one credit never pays for two steps
  localparam int FST = 7;
  localparam int MAXF = int'(rtsfs_pkg::MAXF_RST);
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [rtsfs_pkg::NUM_DI-1:0] contact_cmd = 4'h4;
  logic [rtsfs_pkg::NUM_DI-1:0] di_pin;
  logic fault_fast_stop = 1'b0;
  logic do_pin;
  logic fast_stop_active;
  logic [rtsfs_pkg::FREQ_W-1:0] out_freq;
  logic [31:0] rd;
  int err_count = 0;
  int check_count = 0;
  int acc1, dec1, acc2, dec2, rises, n;
  always #4 ref_clk = ~ref_clk;
  rtsfs_contacts u_rtsfs_contacts (.ref_clk(ref_clk), .contact_cmd(contact_cmd), .di_pin(di_pin));
  rtsfs_ramp_ctrl #(.TICK_CYC(TICK)) u_rtsfs_ramp_ctrl (.ref_clk(ref_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .di_pin(di_pin),
    .fault_fast_stop(fault_fast_stop), .do_pin(do_pin), .out_freq(out_freq), .fast_stop_active(fast_stop_active));
  // ---------------------------------------------
  // bus, compare and expectation helpers
  // ---------------------------------------------
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk_eq(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // slack covers input sync and one partly used ramp tick at each end
  task automatic chk_time(input int got, input int exp);
    check_count++;
    if (got > exp + 2 * TICK + 8 || got < exp - 2 * TICK - 8)
    begin
      err_count++;
      $display("ERROR t=%0t cycles=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge ref_clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, rd);
    chk_eq(rd, exp);
  endtask
  task automatic trig(input int m, input logic on);
    if (m == 0)
      fault_fast_stop <= on;
    else
      contact_cmd[m] <= on ^ (m == 2);
  endtask
  task automatic ramp_wait(input int tgt, input int exp);
    int c;
    logic [rtsfs_pkg::FREQ_W-1:0] prev;
    c = 0;
    rises = 0;
    prev = out_freq;
    while (out_freq !== 12'(tgt) && c < 20000)
    begin
      @(posedge ref_clk);
      c++;
      if (out_freq > prev)
        rises++;
      prev = out_freq;
    end
    chk_time(c, exp);
  endtask
  function automatic int rcyc(input int d, input int t);
    return d * t * rtsfs_pkg::TICKS_PER_UNIT * TICK / MAXF;
  endfunction
  function automatic logic [31:0] ctrl(input logic run, input int tgt);
    return {4'h0, 12'(tgt), 15'h0, run};
  endfunction
  function automatic logic [31:0] rst_val(input int i);
    if (i < 4)
      return 32'(rtsfs_pkg::RAMP_TIME_RST);
    if (i == 4)
      return 32'(rtsfs_pkg::FSTOP_TIME_RST);
    if (i == 6)
      return 32'(rtsfs_pkg::MAXF_RST);
    return (i == 5) ? 32'(rtsfs_pkg::SWF_RST) : 32'h0;
  endfunction
  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  initial
  begin
    repeat (80000) @(posedge ref_clk);
    err_count++;
    finish_test();
  end
  initial
  begin
    rd = $urandom(32'h79864efd);
    acc1 = 1 + $urandom_range(2);
    dec1 = 2 + $urandom_range(1);
    acc2 = acc1 + 1;
    dec2 = dec1 + 1;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    for (int i = 0; i < 12; i++)
      rdchk((i == 11) ? 8'h3C : 8'(4 * i), rst_val(i));
    wr(rtsfs_pkg::OFS_STAT, 32'hFFFF_FFFF);
    wr(8'h3C, 32'h1234_5678);
    rdchk(8'h3C, 32'h0);
    rdchk(rtsfs_pkg::OFS_STAT, 32'h0);
    wr(rtsfs_pkg::OFS_ACC1, acc1);
    wr(rtsfs_pkg::OFS_DEC1, dec1);
    wr(rtsfs_pkg::OFS_ACC2, acc2);
    wr(rtsfs_pkg::OFS_DEC2, dec2);
    rdchk(rtsfs_pkg::OFS_ACC2, acc2);
    n = 100 + $urandom_range(400);
    wr(rtsfs_pkg::OFS_CTRL, ctrl(1'b1, n));
    ramp_wait(n, rcyc(n, acc1));
    rdchk(rtsfs_pkg::OFS_STAT, n);
    wr(rtsfs_pkg::OFS_CTRL, ctrl(1'b0, n));
    ramp_wait(0, rcyc(n, dec1));
    wr(rtsfs_pkg::OFS_SWF, 300);
    wr(rtsfs_pkg::OFS_CTRL, ctrl(1'b1, MAXF));
    ramp_wait(MAXF, rcyc(300, acc2) + rcyc(MAXF - 300, acc1));
    rdchk(rtsfs_pkg::OFS_STAT, MAXF);
    wr(rtsfs_pkg::OFS_CTRL, ctrl(1'b0, MAXF));
    ramp_wait(0, rcyc(MAXF - 300, dec1) + rcyc(300, dec2));
    rdchk(rtsfs_pkg::OFS_STAT, 32'h1 << rtsfs_pkg::STAT_PAIR2_BIT);
    wr(rtsfs_pkg::OFS_DIFN, {24'h0, rtsfs_pkg::FN_RAMP_SEL});
    wr(rtsfs_pkg::OFS_CTRL, ctrl(1'b1, MAXF));
    ramp_wait(MAXF, rcyc(MAXF, acc1));
    contact_cmd[0] <= 1'b1;
    repeat (10) @(posedge ref_clk);
    wr(rtsfs_pkg::OFS_CTRL, ctrl(1'b0, MAXF));
    ramp_wait(0, rcyc(MAXF, dec2));
    contact_cmd[0] <= 1'b0;
    wr(rtsfs_pkg::OFS_DIFN, {8'h00, rtsfs_pkg::FN_FSTOP_NC, rtsfs_pkg::FN_FSTOP_NO, rtsfs_pkg::FN_RAMP_SEL});
    wr(rtsfs_pkg::OFS_FSTOP, FST);
    // source 0 is the fault, 1 the normally open input, 2 the normally closed one
    for (int m = 0; m < 3; m++)
    begin
      wr(rtsfs_pkg::OFS_DOFN, (m == 0) ? 32'h0 : {24'h0, rtsfs_pkg::FN_DO_FSTOP});
      wr(rtsfs_pkg::OFS_CTRL, ctrl(1'b0, MAXF));
      wr(rtsfs_pkg::OFS_CTRL, ctrl(1'b1, MAXF));
      ramp_wait(MAXF, rcyc(MAXF, acc1));
      trig(m, 1'b1);
      n = 0;
      while (fast_stop_active !== 1'b1 && n < 40)
      begin
        @(posedge ref_clk);
        n++;
      end
      if (m != 1)
        trig(m, 1'b0);
      @(posedge ref_clk);
      chk_eq(do_pin, m != 0);
      ramp_wait(0, rcyc(MAXF, FST));
      chk_eq(rises, 0);
      repeat (4) @(posedge ref_clk);
      chk_eq({fast_stop_active, do_pin}, 2'b00);
      wr(rtsfs_pkg::OFS_CTRL, ctrl(1'b1, MAXF));
      repeat (40) @(posedge ref_clk);
      chk_eq(out_freq, 0);
      if (m == 1)
      begin
        wr(rtsfs_pkg::OFS_CTRL, ctrl(1'b0, MAXF));
        wr(rtsfs_pkg::OFS_CTRL, ctrl(1'b1, MAXF));
        repeat (40) @(posedge ref_clk);
        chk_eq(out_freq, 0);
        trig(1, 1'b0);
        repeat (10) @(posedge ref_clk);
        chk_eq(out_freq, 0);
      end
    end
    finish_test();
  end
endmodule
`default_nettype wire
